// file: core/ipb_regs.sv
`timescale 1ns/10ps
module ipb_regs #(
   parameter logic [3:0]  PART_DIGIT3 = 4'h0,
   parameter logic [3:0]  PART_DIGIT2 = 4'h0,
   parameter logic [3:0]  PART_DIGIT1 = 4'h0,
   parameter logic [3:0]  PART_DIGIT0 = 4'h0,
   parameter logic [4:0]  REV_MAJOR   = 5'h00,
   parameter logic [2:0]  REV_MINOR   = 3'h0,
   parameter logic [9:0]  LOT_NUMBER  = 10'h000,
   parameter logic [14:0] SERIAL_ID   = 15'h0000,
   parameter logic [4:0]  WAFER_NUM   = 5'h00
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_on_battery,
   input  wire logic       i_watchdog_input_pin,
   input  wire logic       i_external_interrupt_pin,
   input  wire logic       i_vbat_above_ref,
   input  wire logic [5:0] i_std_ofs,
   input  wire logic [6:0] i_alt_ofs,
   output logic            o_watchdog_pin_gated,
   output logic            o_ext_irq_pin_gated,
   output logic            o_low_battery_flag,
   output logic      [7:0] o_std_ram_addr,
   output logic      [7:0] o_alt_ram_addr
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] pin_sync;
   logic       vbat_sync;
   logic       watchdog_pin_level;
   logic       ext_irq_pin_level;

   ipb_sync2 #(.W(3)) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_async    ({i_vbat_above_ref, i_watchdog_input_pin,
                    i_external_interrupt_pin}),
      .o_sync     ({vbat_sync, pin_sync})
   );

   assign watchdog_pin_level = pin_sync[1];
   assign ext_irq_pin_level  = pin_sync[0];

   // ************************************************************
   // Writable state
   // ************************************************************
   logic [7:0] key_r;
   logic       watchdog_pin_on_battery_r;
   logic       ext_irq_pin_on_battery_r;
   logic       low_battery_polarity_r;
   logic       alternate_page_bit_r;
   logic [1:0] standard_page_field_r;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         key_r <= ipb_pkg::IPB_KEY_RST;
      end else if (i_wr && hit(i_addr, ipb_pkg::IPB_OFS_KEY)) begin
         key_r <= i_wdata;
      end else if (i_wr && hit(i_addr, ipb_pkg::IPB_OFS_PIN_GATING)) begin
         // Each protected write consumes the key, so software re-arms it.
         key_r <= ipb_pkg::IPB_KEY_RST;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         watchdog_pin_on_battery_r <= ipb_pkg::IPB_GATING_RST[1]; // R2
         ext_irq_pin_on_battery_r  <= ipb_pkg::IPB_GATING_RST[0]; // R3
      end else if (i_wr && hit(i_addr, ipb_pkg::IPB_OFS_PIN_GATING)
                   && key_r == ipb_pkg::IPB_KEY_UNLOCK) begin // R1
         watchdog_pin_on_battery_r <= i_wdata[ipb_pkg::IPB_WDOG_BIT]; // R2
         ext_irq_pin_on_battery_r  <= i_wdata[ipb_pkg::IPB_EXT_BIT]; // R3
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         low_battery_polarity_r <= ipb_pkg::IPB_POL_RST;
         alternate_page_bit_r   <= ipb_pkg::IPB_ALT_PAGE_RST;
         standard_page_field_r  <= ipb_pkg::IPB_STD_PAGE_RST;
      end else if (i_wr && hit(i_addr, ipb_pkg::IPB_OFS_RAM_PAGE)) begin
         // Pin-level and reserved bits are dropped here.
         low_battery_polarity_r <= i_wdata[ipb_pkg::IPB_POL_BIT]; // R11
         alternate_page_bit_r   <= i_wdata[ipb_pkg::IPB_ALT_PAGE_BIT]; // R11
         standard_page_field_r  <=
            i_wdata[ipb_pkg::IPB_STD_PAGE_LSB +: 2]; // R16
      end
   end

   // ************************************************************
   // Pin gating, battery flag and RAM addresses
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_watchdog_pin_gated <= 1'h0;
         o_ext_irq_pin_gated  <= 1'h0;
         o_low_battery_flag   <= 1'h0;
         o_std_ram_addr       <= 8'h00;
         o_alt_ram_addr       <= 8'h00;
      end else begin
         o_watchdog_pin_gated <= watchdog_pin_level
            & (~i_on_battery | watchdog_pin_on_battery_r); // R2
         o_ext_irq_pin_gated  <= ext_irq_pin_level
            & (~i_on_battery | ext_irq_pin_on_battery_r); // R3
         o_low_battery_flag   <= low_battery_polarity_r ? vbat_sync
                                                        : ~vbat_sync; // R12
         o_std_ram_addr <= {standard_page_field_r, i_std_ofs}; // R14
         o_alt_ram_addr <= {alternate_page_bit_r, i_alt_ofs}; // R15
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      case (i_addr)
         ipb_pkg::IPB_OFS_PART_UPPER:
            rdata_nxt = {PART_DIGIT3, PART_DIGIT2}; // R4
         ipb_pkg::IPB_OFS_PART_LOWER:
            rdata_nxt = {PART_DIGIT1, PART_DIGIT0}; // R5
         ipb_pkg::IPB_OFS_REVISION:
            rdata_nxt = {REV_MAJOR, REV_MINOR}; // R6
         ipb_pkg::IPB_OFS_LOT_LOW:
            rdata_nxt = LOT_NUMBER[7:0]; // R7
         ipb_pkg::IPB_OFS_SERIAL_UP:
            rdata_nxt = {LOT_NUMBER[9], SERIAL_ID[14:8]}; // R8
         ipb_pkg::IPB_OFS_SERIAL_LOW:
            rdata_nxt = SERIAL_ID[7:0]; // R9
         ipb_pkg::IPB_OFS_WAFER:
            rdata_nxt = {LOT_NUMBER[8], WAFER_NUM, 2'h0}; // R10
         ipb_pkg::IPB_OFS_PIN_GATING:
            rdata_nxt = {watchdog_pin_on_battery_r,
                         ext_irq_pin_on_battery_r, 6'h00}; // R16
         ipb_pkg::IPB_OFS_RAM_PAGE:
            rdata_nxt = {1'h0, low_battery_polarity_r,
                         watchdog_pin_level, ext_irq_pin_level, // R13
                         1'h0, alternate_page_bit_r,
                         standard_page_field_r}; // R11
         default:
            // The key reads as zero so it cannot be snooped.
            rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= rdata_nxt;
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule

// file: core/ipb_pkg.sv
// Functional notes
// [R1] Output control writes land only while the key register holds 0x9D.
// [R2] Output control bit 7 keeps watchdog pin enabled on battery; resets zero.
// [R3] Output control bit 6 keeps interrupt pin enabled on battery; resets zero.
// [R4] Offset 0x28 reads part digits three and two in BCD.
// [R5] Offset 0x29 reads part digits one and zero in BCD.
// [R6] Revision register: major in bits 7:3, minor in bits 2:0.
// [R7] Offset 0x2B reads lot number bits 7:0.
// [R8] Offset 0x2C reads lot bit 9 over serial bits 14:8.
// [R9] Offset 0x2D reads serial bits 7:0.
// [R10] Wafer register: lot bit 8, wafer in 6:2, bits 1:0 reserved.
// [R11] Offset 0x3F: polarity 6, pin levels 5:4, pages 2 and 1:0.
// [R12] Low battery flag follows polarity: below or above reference threshold.
// [R13] Bits 5 and 4 read watchdog and interrupt pin levels.
// [R14] Standard page field forms top two bits of standard RAM address.
// [R15] Alternate page bit forms top bit of alternate RAM address.
// [R16] Read-only and reserved bits ignore writes; reserved bits read zero.
package ipb_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] IPB_OFS_PART_UPPER  = 8'h28;
   localparam logic [7:0] IPB_OFS_PART_LOWER  = 8'h29;
   localparam logic [7:0] IPB_OFS_REVISION    = 8'h2A;
   localparam logic [7:0] IPB_OFS_LOT_LOW     = 8'h2B;
   localparam logic [7:0] IPB_OFS_SERIAL_UP   = 8'h2C;
   localparam logic [7:0] IPB_OFS_SERIAL_LOW  = 8'h2D;
   localparam logic [7:0] IPB_OFS_WAFER       = 8'h2E;
   localparam logic [7:0] IPB_OFS_PIN_GATING  = 8'h30;
   localparam logic [7:0] IPB_OFS_RAM_PAGE    = 8'h3F;
   localparam logic [7:0] IPB_OFS_KEY         = 8'h1F;
   // ************************************************************
   // Key, reset values and field positions
   // ************************************************************
   localparam logic [7:0] IPB_KEY_UNLOCK      = 8'h9D;
   localparam logic [7:0] IPB_KEY_RST         = 8'h00;
   localparam logic [1:0] IPB_GATING_RST      = 2'h0;
   localparam logic       IPB_POL_RST         = 1'h0;
   localparam logic       IPB_ALT_PAGE_RST    = 1'h0;
   localparam logic [1:0] IPB_STD_PAGE_RST    = 2'h0;
   localparam int         IPB_WDOG_BIT        = 7;
   localparam int         IPB_EXT_BIT         = 6;
   localparam int         IPB_POL_BIT         = 6;
   localparam int         IPB_WDOG_LVL_BIT    = 5;
   localparam int         IPB_EXT_LVL_BIT     = 4;
   localparam int         IPB_ALT_PAGE_BIT    = 2;
   localparam int         IPB_STD_PAGE_LSB    = 0;
   localparam int         IPB_WAFER_LSB       = 2;
   localparam int         IPB_STD_OFS_W       = 6;
   localparam int         IPB_ALT_OFS_W       = 7;
endpackage

// file: core/ipb_sync2.sv
`timescale 1ns/10ps
module ipb_sync2 #(
   parameter int W = 2
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_r;

   // The first stage feeds only the second one.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         meta_r <= '0;
         o_sync <= '0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

// file: tb/ipb_regs_asserts.sv
`timescale 1ns/10ps
module ipb_regs_asserts (
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       i_on_battery,
   input wire logic       i_watchdog_input_pin,
   input wire logic       i_external_interrupt_pin,
   input wire logic [5:0] i_std_ofs,
   input wire logic       o_ext_irq_pin_gated,
   input wire logic       o_low_battery_flag,
   input wire logic [7:0] o_std_ram_addr
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_std_offset: assert property (!$past(i_rst) |->
      o_std_ram_addr[5:0] == $past(i_std_ofs)) else $error("std offset");
   a_wdog_level: assert property (
      (!i_rst && $stable(i_watchdog_input_pin)) [*3] ##0
      (i_rd && i_addr == 8'h3F) |=>
      o_rdata[5] == $past(i_watchdog_input_pin)) else $error("pin level");
   a_gate_mains: assert property ((!i_on_battery
      && $stable(i_external_interrupt_pin)) [*4] |->
      o_ext_irq_pin_gated == i_external_interrupt_pin) else $error("gate");
   a_page_rsvd: assert property (i_rd && i_addr == 8'h3F |=>
      !o_rdata[7] && !o_rdata[3]) else $error("reserved bits set");
   a_wafer_rsvd: assert property (i_rd && i_addr == 8'h2E |=>
      o_rdata[1:0] == 2'h0) else $error("wafer reserved bits set");
   a_key_unlock: assert property (i_wr && i_addr == 8'h1F
      && i_wdata == 8'h9D ##1 !i_wr ##1 i_wr && i_addr == 8'h30 ##1 !i_wr
      ##1 i_rd && i_addr == 8'h30 |=>
      o_rdata == {$past(i_wdata[7:6], 3), 6'h00}) else $error("unlock");
   a_page_back: assert property (i_wr && i_addr == 8'h3F ##1 !i_wr
      ##1 i_rd && i_addr == 8'h3F |=> {o_rdata[6], o_rdata[2:0]} ==
      {$past(i_wdata[6], 3), $past(i_wdata[2:0], 3)}) else $error("page");
   c_gating_write: cover property (i_wr && i_addr == 8'h30);
   c_low_battery: cover property (o_low_battery_flag);
   c_battery_pin: cover property (o_ext_irq_pin_gated && i_on_battery);
endmodule
bind ipb_regs ipb_regs_asserts ipb_regs_asserts_inst (.*);

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
   // Identity values are arbitrary test settings.
   localparam logic [9:0]  LOT = 10'h2C3;
   localparam logic [14:0] SER = 15'h5A6B;
   localparam logic [4:0]  WAF = 5'h13;
   localparam logic [15:0] PART = 16'h4237;
   localparam logic [7:0]  REV  = 8'h55;
   logic       i_core_clk, i_rst, i_wr, i_rd, i_on_battery, i_vbat_above_ref;
   logic       i_watchdog_input_pin, i_external_interrupt_pin;
   logic       o_watchdog_pin_gated, o_ext_irq_pin_gated, o_low_battery_flag;
   logic [7:0] i_addr, i_wdata, o_rdata, o_std_ram_addr, o_alt_ram_addr;
   logic [7:0] exp_id [7];
   logic [5:0] i_std_ofs;
   logic [6:0] i_alt_ofs;
   int         fails, compares;
   ipb_regs #(.PART_DIGIT3(PART[15:12]), .PART_DIGIT2(PART[11:8]),
      .PART_DIGIT1(PART[7:4]), .PART_DIGIT0(PART[3:0]),
      .REV_MAJOR(REV[7:3]), .REV_MINOR(REV[2:0]),
      .LOT_NUMBER(LOT), .SERIAL_ID(SER), .WAFER_NUM(WAF)) ipb_regs_inst (.*);
   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1 chk(o_rdata, exp);
      @(posedge i_core_clk);
   endtask
   // Pins cross two synchronising stages, so four edges cover the delay.
   task automatic chk_out(input logic [7:0] exp, input logic [2:0] pg);
      repeat (4) @(posedge i_core_clk);
      #1 chk({5'h00, o_low_battery_flag, o_watchdog_pin_gated,
         o_ext_irq_pin_gated}, exp);
      chk(o_std_ram_addr, {pg[1:0], i_std_ofs});
      chk(o_alt_ram_addr, {pg[2], i_alt_ofs});
      @(posedge i_core_clk);
   endtask
   task automatic report_and_stop;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      report_and_stop;
   end
   initial begin
      {i_rst, i_wr, i_rd, i_on_battery, i_vbat_above_ref} = 5'h11;
      {i_watchdog_input_pin, i_external_interrupt_pin} = 2'h0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_std_ofs = 6'h15;
      i_alt_ofs = 7'h2A;
      fails = 0;
      compares = 0;
      exp_id = '{PART[15:8], PART[7:0], REV, LOT[7:0], {LOT[9], SER[14:8]},
         SER[7:0], {LOT[8], WAF, 2'h0}};
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(posedge i_core_clk);
      rd(8'h30, 8'h00);
      rd(8'h3F, 8'h00);
      rd(8'h00, 8'h00);
      $display("test reset values done");
      for (int k = 0; k < 7; k++) begin
         wr(8'(8'h28 + k), 8'hFF);
         rd(8'(8'h28 + k), exp_id[k]);
      end
      $display("test identity done");
      {i_watchdog_input_pin, i_external_interrupt_pin, i_on_battery} <= 3'h7;
      wr(8'h30, 8'hC0);
      rd(8'h30, 8'h00);
      chk_out(8'h00, 3'h0);
      wr(8'h1F, 8'h9D);
      wr(8'h30, 8'hFF);
      rd(8'h30, 8'hC0);
      wr(8'h30, 8'h00);
      rd(8'h30, 8'hC0);
      chk_out(8'h03, 3'h0);
      wr(8'h1F, 8'h9D);
      wr(8'h30, 8'h80);
      chk_out(8'h02, 3'h0);
      i_on_battery <= 1'b0;
      chk_out(8'h03, 3'h0);
      $display("test pin gating done");
      i_std_ofs <= 6'h2A;
      i_alt_ofs <= 7'h55;
      wr(8'h3F, 8'hFF);
      rd(8'h3F, 8'h77);
      chk_out(8'h07, 3'h7);
      wr(8'h3F, 8'h00);
      chk_out(8'h03, 3'h0);
      {i_vbat_above_ref, i_external_interrupt_pin} <= 2'h0;
      chk_out(8'h06, 3'h0);
      rd(8'h3F, 8'h20);
      $display("test page and battery done");
      // Load every writable bit at 0x30 and 0x3F, then check that a reset in mid-run clears it.
      wr(8'h1F, 8'h9D);
      wr(8'h30, 8'hC0);
      wr(8'h3F, 8'h47);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(posedge i_core_clk);
      rd(8'h30, 8'h00);
      rd(8'h3F, 8'h20);
      chk_out(8'h06, 3'h0);
      $display("test reset in run done");
      report_and_stop;
   end
endmodule
